// *** logic/usp_pkg.sv ***
// Purpose: Shared constants for the serial port block
// Assumes: 50 MHz system clock, 32-bit Avalon-MM register bus
// Notes: Byte addresses; all registers one aligned word
package usp_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);
  // Register byte addresses
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_BAUD = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam logic [3:0] REG_IRQ = 4'h0;
  // Second page (address bit 4 set)
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_CNT = 4'h8;
  // Control fields
  localparam int CTRL_BITS_LSB = 0;
  localparam int CTRL_PAR_EN = 2;
  localparam int CTRL_PAR_ODD = 3;
  localparam int CTRL_STOP2 = 4;
  localparam int CTRL_TX_EN = 5;
  localparam int CTRL_RX_EN = 6;
  localparam int CTRL_RTS_EN = 7;
  localparam int CTRL_CTS_EN = 8;
  localparam int CTRL_BREAK = 9;
  localparam int CTRL_PRIO_LSB = 12;
  localparam logic [14:0] CTRL_RST = 15'h1063;
  // Interrupt status bits
  localparam int IRQ_RX8 = 0;
  localparam int IRQ_IDLE = 1;
  localparam int IRQ_PERR = 2;
  localparam int IRQ_FERR = 3;
  localparam int IRQ_OVR = 4;
  localparam int IRQ_W = 5;
  localparam logic [4:0] RX_BATCH = 5'h08;
  localparam int unsigned RX_DEPTH = 16;
  localparam logic [4:0] RTS_LIMIT = 5'h0c;
  localparam logic [3:0] OVS = 4'hf;
  // Break length in ticks: 13 bit times, one more than the longest frame
  localparam logic [8:0] BRK_TICKS = 9'd208;
endpackage

// *** logic/usp_rx_mem.sv ***
// Purpose: Receive character store with registered read data
// Assumes: Single clock, write and read pointers kept by the caller
// Notes: Read data valid one cycle after the address is applied
`timescale 1ns/1ps
module usp_rx_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// *** logic/usp_top.sv ***
// Purpose: Duplex asynchronous serial port with Avalon-MM registers
// Assumes: One 50 MHz clock, synchronous active-low reset
// Notes: Receiver samples at 16x the bit rate, centre sample taken
// Function
// - Separate transmit and receive lines work independently, allowing full duplex.
// - Character width of 5, 6, 7 or 8 bits, both directions.
// - One or two stop bits sent; receiver checks the same count.
// - Parity off, even (0) or odd (1); generated and checked.
// - Reset defaults: 9600 baud, 8 bits, no parity, one stop bit.
// - Request-to-send needs receive enabled; clear-to-send needs transmit enabled.
// - Default lines enabled with both hardware flow controls off.
// - Break holds the transmit line low longer than a whole frame.
// - Receive interrupt after eight new characters since the last one.
// - Receive interrupt when data waits and line idle one frame time.
// - Receive interrupt priority 1 to 7, larger is higher.
// - Readable character count, zero when empty.
`timescale 1ns/1ps
module usp_top #(
  parameter int DEPTH = usp_pkg::RX_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_irq,
  output logic [2:0] o_irq_prio
);
  localparam int AW = $clog2(DEPTH);
  localparam int IRQ_W_L = usp_pkg::IRQ_W;
  typedef enum logic [2:0] {USP_IDLE, USP_START, USP_DATA, USP_PAR, USP_STOP} usp_state_t;

  function automatic logic [3:0] nbits(input logic [1:0] code);
    nbits = 4'(code) + 4'h5;
  endfunction
  function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < n) begin
        p = p ^ d[k];
      end
    end
    par_of = p;
  endfunction

  // Registers
  logic [14:0] ctrl;
  logic [15:0] baud_div;
  logic [IRQ_W_L-1:0] irq_stat;
  logic [IRQ_W_L-1:0] irq_mask;

  wire [3:0] cfg_bits = nbits(ctrl[usp_pkg::CTRL_BITS_LSB +: 2]);
  wire cfg_par = ctrl[usp_pkg::CTRL_PAR_EN];
  wire cfg_odd = ctrl[usp_pkg::CTRL_PAR_ODD];
  wire cfg_stop2 = ctrl[usp_pkg::CTRL_STOP2];
  wire tx_en = ctrl[usp_pkg::CTRL_TX_EN];
  wire rx_en = ctrl[usp_pkg::CTRL_RX_EN];
  wire rts_en = ctrl[usp_pkg::CTRL_RTS_EN] & rx_en;
  wire cts_en = ctrl[usp_pkg::CTRL_CTS_EN] & tx_en;
  wire [2:0] prio_raw = ctrl[usp_pkg::CTRL_PRIO_LSB +: 3];

  // Oversampling tick, 16 per bit
  logic [15:0] div_cnt;
  logic tick;
  wire [15:0] div16 = {4'h0, baud_div[15:4]};
  always_ff @(posedge i_clk) begin
    if (!i_resetn || div_cnt >= div16) begin
      div_cnt <= 16'h0001;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  always_ff @(posedge i_clk) begin
    tick <= i_resetn && div_cnt >= div16;
  end

  // Pin synchronisers
  logic rxd_m, rxd_s, cts_m, cts_s;
  always_ff @(posedge i_clk) begin
    rxd_m <= i_rxd;
    rxd_s <= rxd_m;
    cts_m <= i_cts_n;
    cts_s <= cts_m;
  end

  // Bus decode
  wire page = i_avs_address[4];
  wire [3:0] offs = {i_avs_address[3:0]};
  wire wr = i_avs_write && !o_avs_waitrequest;
  wire rd = i_avs_read && !o_avs_waitrequest;
  wire wr_data = wr && !page && offs == usp_pkg::REG_DATA;
  wire wr_ctrl = wr && !page && offs == usp_pkg::REG_CTRL;
  wire wr_baud = wr && !page && offs == usp_pkg::REG_BAUD;
  wire wr_irq = wr && page && offs == usp_pkg::REG_IRQ;
  wire wr_mask = wr && page && offs == usp_pkg::REG_MASK;
  wire rd_data = rd && !page && offs == usp_pkg::REG_DATA;

  // Transmitter
  usp_state_t tx_st;
  logic [7:0] tx_hold, tx_sh;
  logic tx_full;
  logic [3:0] tx_os;
  logic [3:0] tx_idx;
  logic [8:0] brk_cnt;
  wire tx_go = tx_full && tx_en && !(cts_en && cts_s);
  wire tx_bit_end = tick && tx_os == usp_pkg::OVS;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_st <= USP_IDLE;
      tx_full <= 1'b0;
      tx_sh <= 8'h00;
      tx_hold <= 8'h00;
      tx_os <= 4'h0;
      tx_idx <= 4'h0;
      o_txd <= 1'b1;
    end else begin
      if (wr_data && !tx_full) begin
        tx_hold <= i_avs_writedata[7:0];
        tx_full <= 1'b1;
      end
      if (tick) begin
        tx_os <= tx_os + 4'h1;
      end
      case (tx_st)
        USP_IDLE: begin
          o_txd <= !(ctrl[usp_pkg::CTRL_BREAK] || brk_cnt != 9'h000);
          tx_os <= 4'h0;
          if (tx_go && brk_cnt == 9'h000 && !ctrl[usp_pkg::CTRL_BREAK]) begin
            tx_sh <= tx_hold;
            tx_full <= 1'b0;
            tx_st <= USP_START;
            o_txd <= 1'b0;
          end
        end
        USP_START: if (tx_bit_end) begin
          tx_st <= USP_DATA;
          tx_idx <= 4'h1;
          o_txd <= tx_sh[0];
        end
        USP_DATA: if (tx_bit_end) begin
          tx_idx <= tx_idx + 4'h1;
          o_txd <= tx_sh[tx_idx[2:0]];
          if (tx_idx == cfg_bits) begin
            tx_st <= cfg_par ? USP_PAR : USP_STOP;
            o_txd <= cfg_par ? par_of(tx_sh, cfg_bits, cfg_odd) : 1'b1;
            tx_idx <= 4'h0;
          end
        end
        USP_PAR: if (tx_bit_end) begin
          tx_st <= USP_STOP;
          o_txd <= 1'b1;
        end
        USP_STOP: if (tx_bit_end) begin
          tx_idx <= tx_idx + 4'h1;
          if (tx_idx == {3'h0, cfg_stop2}) begin
            tx_st <= USP_IDLE;
          end
        end
        default: tx_st <= USP_IDLE;
      endcase
    end
  end

  // Break: 13 bit times of low, longer than any frame; loaded once per request
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      brk_cnt <= 9'h000;
    end else if (ctrl[usp_pkg::CTRL_BREAK] && tx_st == USP_IDLE && brk_cnt == 9'h000) begin
      brk_cnt <= usp_pkg::BRK_TICKS;
    end else if (tick && brk_cnt != 9'h000) begin
      brk_cnt <= brk_cnt - 9'h001;
    end
  end

  // Receiver
  usp_state_t rx_st;
  logic [3:0] rx_os, rx_idx;
  logic [7:0] rx_sh;
  logic rx_perr;
  logic [AW:0] wptr, rptr;
  logic [7:0] rx_q;
  wire [AW:0] count = wptr - rptr;
  wire rx_full = count[AW];
  wire rx_mid = tick && rx_os == 4'h7;
  logic push, perr_ev, ferr_ev, ovr_ev;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_st <= USP_IDLE;
      rx_os <= 4'h0;
      rx_idx <= 4'h0;
      rx_sh <= 8'h00;
      rx_perr <= 1'b0;
      push <= 1'b0;
      perr_ev <= 1'b0;
      ferr_ev <= 1'b0;
      ovr_ev <= 1'b0;
    end else begin
      push <= 1'b0;
      perr_ev <= 1'b0;
      ferr_ev <= 1'b0;
      ovr_ev <= 1'b0;
      if (tick) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_st)
        USP_IDLE: begin
          rx_os <= 4'h0;
          if (rx_en && !rxd_s) begin
            rx_st <= USP_START;
          end
        end
        USP_START: if (rx_mid) begin
          rx_st <= rxd_s ? USP_IDLE : USP_DATA;
          rx_idx <= 4'h0;
          rx_sh <= 8'h00;
        end
        USP_DATA: if (rx_mid) begin
          rx_sh[rx_idx[2:0]] <= rxd_s;
          rx_idx <= rx_idx + 4'h1;
          if (rx_idx + 4'h1 == cfg_bits) begin
            rx_st <= cfg_par ? USP_PAR : USP_STOP;
            rx_idx <= 4'h0;
          end
        end
        USP_PAR: if (rx_mid) begin
          rx_perr <= rxd_s != par_of(rx_sh, cfg_bits, cfg_odd);
          rx_st <= USP_STOP;
        end
        USP_STOP: if (rx_mid) begin
          rx_idx <= rx_idx + 4'h1;
          if (!rxd_s) begin
            ferr_ev <= 1'b1;
          end
          if (rx_idx == {3'h0, cfg_stop2} || !rxd_s) begin
            rx_st <= USP_IDLE;
            push <= !rx_full;
            ovr_ev <= rx_full;
            perr_ev <= cfg_par && rx_perr;
            rx_perr <= 1'b0;
          end
        end
        default: rx_st <= USP_IDLE;
      endcase
    end
  end

  usp_rx_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
    .i_clk(i_clk),
    .i_we(push),
    .i_waddr(wptr[AW-1:0]),
    .i_wdata(rx_sh),
    .i_raddr(rptr[AW-1:0] + AW'(rd_data && count != '0)),
    .o_rdata(rx_q)
  );
  wire pop = rd_data && count != '0;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= wptr + (AW + 1)'(push);
      rptr <= rptr + (AW + 1)'(pop);
    end
  end

  // Receive interrupt events
  logic [4:0] batch;
  logic [7:0] idle_cnt;
  wire [7:0] frame_ticks = {cfg_bits + 4'h2 + 4'(cfg_par) + 4'(cfg_stop2), 4'h0};
  wire ev_rx8 = push && batch == usp_pkg::RX_BATCH - 5'h01;
  wire ev_idle = tick && count != '0 && rx_st == USP_IDLE && idle_cnt == frame_ticks;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      batch <= 5'h00;
      idle_cnt <= 8'h00;
    end else begin
      if (ev_rx8 || ev_idle) begin
        batch <= 5'h00;
      end else if (push) begin
        batch <= batch + 5'h01;
      end
      if (rx_st != USP_IDLE || push || count == '0) begin
        idle_cnt <= 8'h00;
      end else if (tick && idle_cnt <= frame_ticks) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  wire [IRQ_W_L-1:0] ev = {ovr_ev, ferr_ev, perr_ev, ev_idle, ev_rx8};
  wire [IRQ_W_L-1:0] w1c = wr_irq ? i_avs_writedata[IRQ_W_L-1:0] : '0;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | ev; // Set wins over clear
    end
  end

  // Register writes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl <= usp_pkg::CTRL_RST;
      baud_div <= usp_pkg::BAUD_DIV_RST;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= i_avs_writedata[14:0];
      end else if (brk_cnt == 9'h001 && tick) begin
        ctrl[usp_pkg::CTRL_BREAK] <= 1'b0;
      end
      if (wr_baud && i_avs_writedata[15:4] != 12'h000) begin
        baud_div <= i_avs_writedata[15:0];
      end
      if (wr_mask) begin
        irq_mask <= i_avs_writedata[IRQ_W_L-1:0];
      end
    end
  end

  // Read mux and one wait cycle per access
  logic rd_pend;
  wire [AW:0] rts_limit = (AW + 1)'(usp_pkg::RTS_LIMIT);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case ({page, offs})
      {1'b0, usp_pkg::REG_CTRL}: rd_mux = {17'h0, ctrl};
      {1'b0, usp_pkg::REG_BAUD}: rd_mux = {16'h0, baud_div};
      {1'b0, usp_pkg::REG_STAT}: rd_mux = {24'h0, rx_st != USP_IDLE, tx_st != USP_IDLE,
                                            tx_full, o_rts_n, cts_s, brk_cnt != 9'h000,
                                            count == '0, rx_full};
      {1'b1, usp_pkg::REG_IRQ}: rd_mux = {27'h0, irq_stat};
      {1'b1, usp_pkg::REG_MASK}: rd_mux = {27'h0, irq_mask};
      {1'b1, usp_pkg::REG_CNT}: rd_mux = {{(31 - AW){1'b0}}, count};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      rd_pend <= 1'b0;
      o_rts_n <= 1'b1;
      o_irq <= 1'b0;
      o_irq_prio <= 3'h1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest && !rd_pend);
      rd_pend <= !o_avs_waitrequest;
      o_avs_readdata <= (i_avs_read && !page && offs == usp_pkg::REG_DATA)
                        ? {23'h0, count == '0, rx_q} : rd_mux;
      o_rts_n <= !(rts_en && count < rts_limit);
      o_irq <= |(irq_stat & irq_mask);
      o_irq_prio <= prio_raw == 3'h0 ? 3'h1 : prio_raw;
    end
  end

  a_break_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(brk_cnt == usp_pkg::BRK_TICKS) |-> ##1 !o_txd [*8])
    else $error("Break line not low");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    |(irq_stat & irq_mask) |=> o_irq)
    else $error("Interrupt not raised");
  a_prio_range: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 o_irq_prio != 3'h0)
    else $error("Priority out of range");
  a_rx8_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ev_rx8 |=> irq_stat[usp_pkg::IRQ_RX8])
    else $error("Batch event lost");
  a_idle_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ev_idle |-> count != '0 ##1 irq_stat[usp_pkg::IRQ_IDLE])
    else $error("Idle event lost");
  a_cts_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (tx_st == USP_IDLE && cts_en && cts_s) |=> tx_st == USP_IDLE)
    else $error("Sent while clear-to-send off");
  a_start_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (tx_st == USP_START) |-> !o_txd)
    else $error("Start bit not low");
  a_count_bound: assert property (@(posedge i_clk) disable iff (!i_resetn)
    count <= (AW + 1)'(DEPTH))
    else $error("Count beyond depth");
  c_rx_char: cover property (@(posedge i_clk) disable iff (!i_resetn) push);
  c_tx_frame: cover property (@(posedge i_clk) disable iff (!i_resetn)
    tx_st == USP_STOP ##1 tx_st == USP_IDLE);
  c_break: cover property (@(posedge i_clk) disable iff (!i_resetn) brk_cnt == 9'h001);
endmodule

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the serial port block
// Assumes: Bit period set to 32 clocks after reset
// Notes: Row loop covers frame formats, hand tests cover reset, irq, break, flow
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [14:0] ctrl; logic [7:0] ch;} usp_row_t;
  logic i_clk;
  logic i_resetn;
  logic [4:0] av_addr;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wd;
  logic [31:0] av_rdata;
  logic av_wait;
  logic rxd;
  logic cts_n;
  logic txd;
  logic rts_n;
  logic irq;
  logic [2:0] prio;
  logic [7:0] d;
  logic [7:0] m;
  logic ok;
  int nb;
  int low;
  int mismatches;
  int checks_done;
  usp_row_t rows [4];
  usp_top i_usp_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_rxd(rxd),
    .i_cts_n(cts_n), .o_txd(txd), .o_rts_n(rts_n), .o_irq(irq), .o_irq_prio(prio));
  usp_remote #(.BIT(32)) i_usp_remote (.i_clk(i_clk), .i_txd(txd), .o_rxd(rxd));
  always #10 i_clk = ~i_clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    av_addr <= a;
    av_wd <= wd;
    av_wr <= wr;
    av_rd <= ~wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    q = av_rdata;
    if (n >= 50) mismatches++;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] msk, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & msk, e);
  endtask
  task automatic wait_cnt();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0;
    while (q === 32'h0 && n < 500) begin
      bus(1'b0, 5'h18, 32'h0, q);
      n++;
    end
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    av_addr = 5'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    cts_n = 1'b0;
    mismatches = 0;
    checks_done = 0;
    rows = '{'{15'h0060, 8'hf5}, '{15'h0065, 8'h2c}, '{15'h007e, 8'h53}, '{15'h0063, 8'ha5}};
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    wr(5'h08, 32'h20);
    foreach (rows[k]) begin
      nb = rows[k].ctrl[1:0] + 5;
      m = 8'hff >> (8 - nb);
      wr(5'h04, {17'h0, rows[k].ctrl});
      fork
        i_usp_remote.send(rows[k].ch ^ 8'h5a, nb, rows[k].ctrl[2], rows[k].ctrl[3],
                          rows[k].ctrl[4] ? 2 : 1);
        begin
          wr(5'h00, {24'h0, rows[k].ch});
          i_usp_remote.get(nb, rows[k].ctrl[2], rows[k].ctrl[3], rows[k].ctrl[4] ? 2 : 1,
                           d, ok);
        end
      join
      chk({31'h0, ok}, 32'h1);
      chk({24'h0, d}, {24'h0, rows[k].ch & m});
      wait_cnt();
      rdc(5'h00, 32'hff, {24'h0, (rows[k].ch ^ 8'h5a) & m});
    end
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    chk({29'h0, txd, rts_n, irq}, 32'h6);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    rdc(5'h04, 32'h7fff, 32'h1063);
    rdc(5'h08, 32'hffff, 32'h1458);
    rdc(5'h18, 32'hffffffff, 32'h0);
    rdc(5'h0c, 32'h2, 32'h2);
    rdc(5'h1c, 32'hffffffff, 32'h0);
    wr(5'h08, 32'h20);
    wr(5'h14, 32'h1);
    wr(5'h04, 32'h5063);
    for (int i = 0; i < 7; i++) i_usp_remote.send(8'h30 + i, 8, 1'b0, 1'b0, 1);
    rdc(5'h10, 32'h1, 32'h0);
    i_usp_remote.send(8'h37, 8, 1'b0, 1'b0, 1);
    repeat (40) @(posedge i_clk);
    @(negedge i_clk);
    chk({28'h0, irq, prio}, 32'hd);
    rdc(5'h10, 32'h1, 32'h1);
    rdc(5'h18, 32'hffffffff, 32'h8);
    for (int i = 0; i < 8; i++) rdc(5'h00, 32'hff, 32'h30 + i);
    wr(5'h10, 32'h1f);
    i_usp_remote.send(8'hc3, 8, 1'b0, 1'b0, 1);
    repeat (700) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    wr(5'h14, 32'h2);
    rdc(5'h10, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rdc(5'h00, 32'hff, 32'hc3);
    wr(5'h10, 32'h1f);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, irq}, 32'h0);
    wr(5'h04, 32'h5263);
    low = 0;
    for (int i = 0; i < 2000 && (low == 0 || txd === 1'b0); i++) begin
      @(negedge i_clk);
      if (txd === 1'b0) low++;
    end
    chk({31'h0, low > 320}, 32'h1);
    @(posedge i_clk);
    cts_n <= 1'b1;
    wr(5'h04, 32'h5163);
    wr(5'h00, 32'h3c);
    low = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge i_clk);
      if (txd !== 1'b1) low++;
    end
    chk(low, 0);
    @(posedge i_clk);
    cts_n <= 1'b0;
    i_usp_remote.get(8, 1'b0, 1'b0, 1, d, ok);
    chk({23'h0, ok, d}, 32'h13c);
    wr(5'h04, 32'h50e3);
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, rts_n}, 32'h0);
    give_verdict();
  end
endmodule

// *** verification/usp_remote.sv ***
// Purpose: Remote serial device model facing the serial port lines
// Assumes: Bit period in system clocks, receive line idles high
// Notes: Sends frames on the port's receive line, decodes its transmit line
`timescale 1ns/1ps
module usp_remote #(
  parameter int BIT = 32
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  initial o_rxd = 1'b1;
  task automatic put(input logic b);
    o_rxd <= b;
    repeat (BIT) @(posedge i_clk);
  endtask
  // One frame out, idle high afterwards
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic podd,
                      input int ns);
    logic p;
    p = podd;
    @(posedge i_clk);
    put(1'b0);
    for (int i = 0; i < nb; i++) begin
      put(d[i]);
      p = p ^ d[i];
    end
    if (pen) put(p);
    for (int i = 0; i < ns; i++) put(1'b1);
  endtask
  // Centre-sampled decode of one frame
  task automatic get(input int nb, input logic pen, input logic podd, input int ns,
                     output logic [7:0] d, output logic ok);
    logic p;
    int n;
    d = 8'h00;
    p = podd;
    n = 0;
    while (i_txd !== 1'b0 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (BIT / 2) @(negedge i_clk);
    ok = (i_txd === 1'b0) && (n < 4000);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(negedge i_clk);
      d[i] = i_txd;
      p = p ^ i_txd;
    end
    if (pen) begin
      repeat (BIT) @(negedge i_clk);
      ok = ok && (i_txd === p);
    end
    for (int i = 0; i < ns; i++) begin
      repeat (BIT) @(negedge i_clk);
      ok = ok && (i_txd === 1'b1);
    end
  endtask
endmodule
